// File: rtl/split_int_pkg.sv
// constants for the split interrupt descriptor upper words block
package split_int_pkg;
   // ==========================================================
   // register byte offsets
   localparam int          ADDR_W      = 5;
   localparam logic [4:0]  OFF_WORD4   = 5'h00;
   localparam logic [4:0]  OFF_WORD5   = 5'h04;
   localparam logic [4:0]  OFF_WORD6   = 5'h08;
   localparam logic [4:0]  OFF_WORD7   = 5'h0C;
   localparam logic [4:0]  OFF_CTRL    = 5'h10;
   localparam logic [4:0]  OFF_IRQSTAT = 5'h14;
   localparam logic [4:0]  OFF_IRQMASK = 5'h18;
   localparam logic [4:0]  OFF_FRAME   = 5'h1C;
   // ==========================================================
   // field layout
   localparam int          UF_N        = 8;
   localparam int          UF_W        = 3;
   localparam int          CNT_W       = 8;
   localparam int          RES_W       = 3;
   localparam int          FRAME_W     = 5;
   localparam int          MASK_LSB    = 0;
   localparam int          RES_BASE    = 8;
   localparam int          CTRL_DIR    = 0;
   localparam int          CTRL_FRAME  = 8;
   localparam int          RES_ERR     = 0;
   localparam int          RES_BABBLE  = 1;
   localparam int          RES_UNDER   = 2;
   localparam int          IN_SS_LIMIT = 4;
   localparam int          RSV_LSB     = 8;
   localparam int          RSV_W       = 24;
   // count field of microframe n: word index (0 = word 4) and lsb
   localparam int          CNT_WORD [UF_N] = '{1, 1, 1, 2, 2, 2, 2, 3};
   localparam int          CNT_LSB  [UF_N] = '{8, 16, 24, 0, 8, 16, 24, 0};
   // ==========================================================
   // interrupt bits and bus answers
   localparam int          IRQ_W       = 3;
   localparam int          IRQ_SS      = 0;
   localparam int          IRQ_CS      = 1;
   localparam int          IRQ_ERR     = 2;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;
endpackage

// File: rtl/uframe_slot.sv
// one microframe's received byte count and result code
`timescale 1ns/1ps
module uframe_slot
(
   input  wire logic                                sys_clk,
   input  wire logic                                rst,
   input  wire logic                                hwHit,
   input  wire logic [split_int_pkg::CNT_W-1:0]     hwCount,
   input  wire logic [split_int_pkg::RES_W-1:0]     hwCode,
   input  wire logic                                swCntWe,
   input  wire logic [split_int_pkg::CNT_W-1:0]     swCnt,
   input  wire logic                                swResWe,
   input  wire logic [split_int_pkg::RES_W-1:0]     swRes,
   output logic      [split_int_pkg::CNT_W-1:0]     count,
   output logic      [split_int_pkg::RES_W-1:0]     result
);
   logic [split_int_pkg::CNT_W-1:0] count_ff;
   logic [split_int_pkg::CNT_W-1:0] nxt_count;
   logic [split_int_pkg::RES_W-1:0] result_ff;
   logic [split_int_pkg::RES_W-1:0] nxt_result;

   // hardware result beats a software write in the same cycle
   always_comb
   begin
      nxt_count  = count_ff;
      nxt_result = result_ff;
      if (swCntWe)
         nxt_count = swCnt;
      if (swResWe)
         nxt_result = swRes;
      if (hwHit)
      begin
         nxt_count  = hwCount;
         nxt_result = hwCode;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         count_ff  <= '0;
         result_ff <= '0;
      end
      else
      begin
         count_ff  <= nxt_count;
         result_ff <= nxt_result;
      end
   end

   assign count  = count_ff;
   assign result = result_ff;

   overwrite_a: assert property (@(posedge sys_clk) disable iff (rst)
      hwHit |=> count_ff == $past(hwCount))
      else $error("byte count not overwritten by latest value");
endmodule

// File: rtl/irq_status.sv
// sticky event status, mask and interrupt level
`timescale 1ns/1ps
module irq_status
(
   input  wire logic                                sys_clk,
   input  wire logic                                rst,
   input  wire logic [split_int_pkg::IRQ_W-1:0]     evt,
   input  wire logic                                clrWe,
   input  wire logic [split_int_pkg::IRQ_W-1:0]     clrBits,
   input  wire logic                                maskWe,
   input  wire logic [split_int_pkg::IRQ_W-1:0]     maskBits,
   output logic      [split_int_pkg::IRQ_W-1:0]     status,
   output logic      [split_int_pkg::IRQ_W-1:0]     mask,
   output logic                                     irq
);
   logic [split_int_pkg::IRQ_W-1:0] stat_ff;
   logic [split_int_pkg::IRQ_W-1:0] nxt_stat;
   logic [split_int_pkg::IRQ_W-1:0] mask_ff;
   logic [split_int_pkg::IRQ_W-1:0] nxt_mask;

   // set wins over a write-one-to-clear in the same cycle
   always_comb
   begin
      nxt_stat = (stat_ff & ~(clrWe ? clrBits : '0)) | evt;
      nxt_mask = maskWe ? maskBits : mask_ff;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         stat_ff <= '0;
         mask_ff <= '0;
      end
      else
      begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
      end
   end

   assign status = stat_ff;
   assign mask   = mask_ff;
   assign irq    = |(stat_ff & mask_ff);

   set_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
      |evt |=> (stat_ff & $past(evt)) == $past(evt))
      else $error("event lost against clear");
endmodule

// File: rtl/split_interrupt_descriptor_upper.sv
// split interrupt descriptor upper words: execution, write-back and register slave
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module split_interrupt_descriptor_upper
(
   input  wire logic                                sys_clk,
   input  wire logic                                rst,
   input  wire logic [split_int_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                                s_axi_awvalid,
   output logic                                     s_axi_awready,
   input  wire logic [31:0]                         s_axi_wdata,
   input  wire logic [3:0]                          s_axi_wstrb,
   input  wire logic                                s_axi_wvalid,
   output logic                                     s_axi_wready,
   output logic [1:0]                               s_axi_bresp,
   output logic                                     s_axi_bvalid,
   input  wire logic                                s_axi_bready,
   input  wire logic [split_int_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                                s_axi_arvalid,
   output logic                                     s_axi_arready,
   output logic [31:0]                              s_axi_rdata,
   output logic [1:0]                               s_axi_rresp,
   output logic                                     s_axi_rvalid,
   input  wire logic                                s_axi_rready,
   input  wire logic                                uframeStart,
   input  wire logic [split_int_pkg::UF_W-1:0]      uframeNum,
   input  wire logic [split_int_pkg::FRAME_W-1:0]   frameNum,
   input  wire logic                                xferDone,
   input  wire logic                                xferIsCs,
   input  wire logic [split_int_pkg::UF_W-1:0]      xferUframe,
   input  wire logic [split_int_pkg::CNT_W-1:0]     rxCount,
   input  wire logic                                errTxn,
   input  wire logic                                errBabble,
   input  wire logic                                errUnderrun,
   output logic                                     ssIssue,
   output logic                                     csIssue,
   output logic [split_int_pkg::UF_W-1:0]           issueUframe,
   output logic                                     irq
);
   localparam int N = split_int_pkg::UF_N;

   // ==========================================================
   // register slave state
   logic [4:0]  awAddr_ff,  nxt_awAddr;
   logic        awHeld_ff,  nxt_awHeld;
   logic [31:0] wData_ff,   nxt_wData;
   logic [3:0]  wStrb_ff,   nxt_wStrb;
   logic        wHeld_ff,   nxt_wHeld;
   logic        bValid_ff,  nxt_bValid;
   logic [1:0]  bResp_ff,   nxt_bResp;
   logic        rValid_ff,  nxt_rValid;
   logic [31:0] rData_ff,   nxt_rData;
   logic [1:0]  rResp_ff,   nxt_rResp;
   // descriptor and control state
   logic [N-1:0] ssMask_ff, nxt_ssMask;
   logic [N-1:0] csMask_ff, nxt_csMask;
   logic [N-1:0] ssArmed_ff, nxt_ssArmed;
   logic [N-1:0] csArmed_ff, nxt_csArmed;
   logic [split_int_pkg::RSV_W-1:0]   rsv_ff, nxt_rsv;
   logic                              dirIn_ff, nxt_dirIn;
   logic [split_int_pkg::FRAME_W-1:0] frameSel_ff, nxt_frameSel;
   logic                              ssIssue_ff, nxt_ssIssue;
   logic                              csIssue_ff, nxt_csIssue;
   logic [split_int_pkg::UF_W-1:0]    issueUf_ff, nxt_issueUf;

   logic        wrFire;
   logic [3:0]  wrWord;
   logic        wrCtrl, wrStat, wrMask, wrOk;
   logic [31:0] wrOld, wrMerged, strbMask, ctrlWord;
   logic [31:0] wordRd [4];
   logic        frameHit, ssAllowed;
   logic [N-1:0] hwHit;
   logic [split_int_pkg::RES_W-1:0] hwCode;
   logic [split_int_pkg::CNT_W-1:0] cntQ [N];
   logic [split_int_pkg::RES_W-1:0] resQ [N];
   logic [split_int_pkg::IRQ_W-1:0] irqEvt, irqStat, irqMaskQ;

   // ==========================================================
   // descriptor word views
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         wordRd[i] = split_int_pkg::RST_WORD;
      wordRd[0][split_int_pkg::MASK_LSB +: N] = ssMask_ff;
      wordRd[1][split_int_pkg::MASK_LSB +: N] = csMask_ff;
      wordRd[3][split_int_pkg::RSV_LSB +: split_int_pkg::RSV_W] = rsv_ff;
      for (int n = 0; n < N; n++)
      begin
         wordRd[split_int_pkg::CNT_WORD[n]][split_int_pkg::CNT_LSB[n] +: 8] = cntQ[n];
         wordRd[0][split_int_pkg::RES_BASE + split_int_pkg::RES_W * n +: 3] = resQ[n];
      end
      ctrlWord = split_int_pkg::RST_WORD;
      ctrlWord[split_int_pkg::CTRL_DIR] = dirIn_ff;
      ctrlWord[split_int_pkg::CTRL_FRAME +: split_int_pkg::FRAME_W] = frameSel_ff;
   end

   // ==========================================================
   // write decode
   always_comb
   begin
      wrFire = awHeld_ff && wHeld_ff && !bValid_ff;
      wrWord = 4'h0;
      wrCtrl = 1'b0;
      wrStat = 1'b0;
      wrMask = 1'b0;
      wrOk   = 1'b1;
      wrOld  = split_int_pkg::RST_WORD;
      if (awAddr_ff == split_int_pkg::OFF_WORD4)
      begin
         wrWord[0] = wrFire;
         wrOld     = wordRd[0];
      end
      else if (awAddr_ff == split_int_pkg::OFF_WORD5)
      begin
         wrWord[1] = wrFire;
         wrOld     = wordRd[1];
      end
      else if (awAddr_ff == split_int_pkg::OFF_WORD6)
      begin
         wrWord[2] = wrFire;
         wrOld     = wordRd[2];
      end
      else if (awAddr_ff == split_int_pkg::OFF_WORD7)
      begin
         wrWord[3] = wrFire;
         wrOld     = wordRd[3];
      end
      else if (awAddr_ff == split_int_pkg::OFF_CTRL)
      begin
         wrCtrl = wrFire;
         wrOld  = ctrlWord;
      end
      else if (awAddr_ff == split_int_pkg::OFF_IRQSTAT)
         wrStat = wrFire;
      else if (awAddr_ff == split_int_pkg::OFF_IRQMASK)
      begin
         wrMask = wrFire;
         wrOld[split_int_pkg::IRQ_W-1:0] = irqMaskQ;
      end
      else if (awAddr_ff != split_int_pkg::OFF_FRAME)
         wrOk = 1'b0;
      strbMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
      wrMerged = (wrOld & ~strbMask) | (wData_ff & strbMask);
   end

   // ==========================================================
   // execution: issue and write-back
   always_comb
   begin
      frameHit  = frameNum == frameSel_ff;
      // IN start splits beyond microframe 3 are never placed
      ssAllowed = !dirIn_ff || (uframeNum < split_int_pkg::UF_W'(split_int_pkg::IN_SS_LIMIT));
      hwCode = '0;
      hwCode[split_int_pkg::RES_ERR]    = errTxn;
      hwCode[split_int_pkg::RES_BABBLE] = errBabble && dirIn_ff;
      hwCode[split_int_pkg::RES_UNDER]  = errUnderrun && !dirIn_ff;
      nxt_ssMask  = wrWord[0] ? wrMerged[split_int_pkg::MASK_LSB +: N] : ssMask_ff;
      nxt_csMask  = wrWord[1] ? wrMerged[split_int_pkg::MASK_LSB +: N] : csMask_ff;
      nxt_rsv     = wrWord[3] ? wrMerged[split_int_pkg::RSV_LSB +: split_int_pkg::RSV_W] : rsv_ff;
      nxt_ssArmed = ssArmed_ff;
      nxt_csArmed = csArmed_ff;
      nxt_ssIssue = 1'b0;
      nxt_csIssue = 1'b0;
      nxt_issueUf = issueUf_ff;
      if (uframeStart)
      begin
         nxt_issueUf = uframeNum;
         nxt_ssIssue = frameHit && ssMask_ff[uframeNum] && ssAllowed;
         nxt_csIssue = frameHit && dirIn_ff && csMask_ff[uframeNum];
         if (nxt_ssIssue)
            nxt_ssArmed[uframeNum] = 1'b1;
         if (nxt_csIssue)
            nxt_csArmed[uframeNum] = 1'b1;
      end
      for (int n = 0; n < N; n++)
      begin
         hwHit[n] = xferDone && (xferUframe == n[split_int_pkg::UF_W-1:0]) &&
                    (xferIsCs ? (csArmed_ff[n] && csMask_ff[n] && dirIn_ff) : 
                                (ssArmed_ff[n] && ssMask_ff[n]));
         if (hwHit[n] && !xferIsCs)
         begin
            nxt_ssMask[n]  = 1'b0;
            nxt_ssArmed[n] = 1'b0;
         end
         if (hwHit[n] && xferIsCs)
         begin
            nxt_csMask[n]  = 1'b0;
            nxt_csArmed[n] = 1'b0;
         end
      end
      irqEvt = '0;
      irqEvt[split_int_pkg::IRQ_SS]  = |hwHit && !xferIsCs;
      irqEvt[split_int_pkg::IRQ_CS]  = |hwHit && xferIsCs;
      irqEvt[split_int_pkg::IRQ_ERR] = |hwHit && (hwCode != '0);
      nxt_dirIn    = wrCtrl ? wrMerged[split_int_pkg::CTRL_DIR] : dirIn_ff;
      nxt_frameSel = wrCtrl ? wrMerged[split_int_pkg::CTRL_FRAME +: split_int_pkg::FRAME_W]
                            : frameSel_ff;
   end

   generate
      for (genvar g = 0; g < N; g++)
      begin : slot
         uframe_slot u_slot
         (
            .sys_clk (sys_clk),
            .rst     (rst),
            .hwHit   (hwHit[g]),
            .hwCount (rxCount),
            .hwCode  (hwCode),
            .swCntWe (wrWord[split_int_pkg::CNT_WORD[g]]),
            .swCnt   (wrMerged[split_int_pkg::CNT_LSB[g] +: 8]),
            .swResWe (wrWord[0]),
            .swRes   (wrMerged[split_int_pkg::RES_BASE + split_int_pkg::RES_W * g +: 3]),
            .count   (cntQ[g]),
            .result  (resQ[g])
         );
      end
   endgenerate

   irq_status u_irq
   (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .evt      (irqEvt),
      .clrWe    (wrStat),
      .clrBits  (wrMerged[split_int_pkg::IRQ_W-1:0]),
      .maskWe   (wrMask),
      .maskBits (wrMerged[split_int_pkg::IRQ_W-1:0]),
      .status   (irqStat),
      .mask     (irqMaskQ),
      .irq      (irq)
   );

   // ==========================================================
   // bus channel next values
   always_comb
   begin
      nxt_awAddr = awAddr_ff;
      nxt_awHeld = awHeld_ff;
      nxt_wData  = wData_ff;
      nxt_wStrb  = wStrb_ff;
      nxt_wHeld  = wHeld_ff;
      nxt_bValid = bValid_ff;
      nxt_bResp  = bResp_ff;
      nxt_rValid = rValid_ff;
      nxt_rData  = rData_ff;
      nxt_rResp  = rResp_ff;
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_awAddr = s_axi_awaddr;
         nxt_awHeld = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_wData = s_axi_wdata;
         nxt_wStrb = s_axi_wstrb;
         nxt_wHeld = 1'b1;
      end
      if (wrFire)
      begin
         nxt_awHeld = 1'b0;
         nxt_wHeld  = 1'b0;
         nxt_bValid = 1'b1;
         nxt_bResp  = wrOk ? split_int_pkg::RESP_OKAY : split_int_pkg::RESP_SLVERR;
      end
      else if (bValid_ff && s_axi_bready)
         nxt_bValid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_rValid = 1'b1;
         nxt_rResp  = split_int_pkg::RESP_OKAY;
         nxt_rData  = split_int_pkg::RST_WORD;
         if (s_axi_araddr == split_int_pkg::OFF_WORD4)
            nxt_rData = wordRd[0];
         else if (s_axi_araddr == split_int_pkg::OFF_WORD5)
            nxt_rData = wordRd[1];
         else if (s_axi_araddr == split_int_pkg::OFF_WORD6)
            nxt_rData = wordRd[2];
         else if (s_axi_araddr == split_int_pkg::OFF_WORD7)
            nxt_rData = wordRd[3];
         else if (s_axi_araddr == split_int_pkg::OFF_CTRL)
            nxt_rData = ctrlWord;
         else if (s_axi_araddr == split_int_pkg::OFF_IRQSTAT)
            nxt_rData[split_int_pkg::IRQ_W-1:0] = irqStat;
         else if (s_axi_araddr == split_int_pkg::OFF_IRQMASK)
            nxt_rData[split_int_pkg::IRQ_W-1:0] = irqMaskQ;
         else if (s_axi_araddr == split_int_pkg::OFF_FRAME)
            nxt_rData[split_int_pkg::FRAME_W-1:0] = frameNum;
         else
            nxt_rResp = split_int_pkg::RESP_SLVERR;
      end
      else if (rValid_ff && s_axi_rready)
         nxt_rValid = 1'b0;
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         awAddr_ff   <= '0;
         awHeld_ff   <= 1'b0;
         wData_ff    <= '0;
         wStrb_ff    <= '0;
         wHeld_ff    <= 1'b0;
         bValid_ff   <= 1'b0;
         bResp_ff    <= split_int_pkg::RESP_OKAY;
         rValid_ff   <= 1'b0;
         rData_ff    <= '0;
         rResp_ff    <= split_int_pkg::RESP_OKAY;
         ssMask_ff   <= '0;
         csMask_ff   <= '0;
         ssArmed_ff  <= '0;
         csArmed_ff  <= '0;
         rsv_ff      <= '0;
         dirIn_ff    <= 1'b0;
         frameSel_ff <= '0;
         ssIssue_ff  <= 1'b0;
         csIssue_ff  <= 1'b0;
         issueUf_ff  <= '0;
      end
      else
      begin
         awAddr_ff   <= nxt_awAddr;
         awHeld_ff   <= nxt_awHeld;
         wData_ff    <= nxt_wData;
         wStrb_ff    <= nxt_wStrb;
         wHeld_ff    <= nxt_wHeld;
         bValid_ff   <= nxt_bValid;
         bResp_ff    <= nxt_bResp;
         rValid_ff   <= nxt_rValid;
         rData_ff    <= nxt_rData;
         rResp_ff    <= nxt_rResp;
         ssMask_ff   <= nxt_ssMask;
         csMask_ff   <= nxt_csMask;
         ssArmed_ff  <= nxt_ssArmed;
         csArmed_ff  <= nxt_csArmed;
         rsv_ff      <= nxt_rsv;
         dirIn_ff    <= nxt_dirIn;
         frameSel_ff <= nxt_frameSel;
         ssIssue_ff  <= nxt_ssIssue;
         csIssue_ff  <= nxt_csIssue;
         issueUf_ff  <= nxt_issueUf;
      end
   end

   assign s_axi_awready = !awHeld_ff && !bValid_ff;
   assign s_axi_wready  = !wHeld_ff && !bValid_ff;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;
   assign ssIssue       = ssIssue_ff;
   assign csIssue       = csIssue_ff;
   assign issueUframe   = issueUf_ff;

   // ==========================================================
   // checks
   ss_select_a: assert property (@(posedge sys_clk) disable iff (rst)
      ssIssue_ff |-> $past(ssMask_ff[uframeNum] && frameHit && uframeStart))
      else $error("start split issued without mask bit or frame match");
   cs_in_only_a: assert property (@(posedge sys_clk) disable iff (rst)
      csIssue_ff |-> $past(dirIn_ff && csMask_ff[uframeNum] && frameHit))
      else $error("complete split issued outside mask or for OUT");
   in_ss_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ssIssue_ff && $past(dirIn_ff)) |-> issueUf_ff < 3'h4)
      else $error("IN start split in microframe 4 or above");
   cs_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      (xferDone && xferIsCs && hwHit[xferUframe] && !wrWord[1])
      |=> !csMask_ff[$past(xferUframe)])
      else $error("complete-split mask bit not cleared");
   count7_wb_a: assert property (@(posedge sys_clk) disable iff (rst)
      hwHit[7] |-> ##2 wordRd[3][7:0] == $past(rxCount, 2))
      else $error("microframe 7 count not in word 7");
   code_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
      (|hwHit && dirIn_ff) |=> !resQ[$past(xferUframe)][2])
      else $error("underrun reported on IN");
   rsv_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
      !wrWord[3] |=> $stable(rsv_ff))
      else $error("reserved word 7 bits changed");
   wr_resp_a: assert property (@(posedge sys_clk) disable iff (rst)
      wrFire |=> bValid_ff ##0 (bResp_ff == (wrOk ? 2'h0 : 2'h2)) [*1])
      else $error("write response missing after write");
endmodule

// File: testbench/split_device_model.sv
// far-side device behind the hub: answers an issued split after a fixed delay, dropping issues seen while it waits
`timescale 1ns/1ps
module split_device_model
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       ssIssue,
   input  wire logic       csIssue,
   input  wire logic [2:0] issueUframe,
   input  wire logic [7:0] cnt,
   input  wire logic [2:0] err,
   output logic            xferDone,
   output logic            xferIsCs,
   output logic [2:0]      xferUframe,
   output logic [7:0]      rxCount,
   output logic [2:0]      errs
);
   logic kind;
   initial
   begin
      xferDone = 1'h0;
      xferIsCs = 1'h0;
      xferUframe = 3'h0;
      rxCount = 8'h0;
      errs = 3'h0;
   end
   // payload lines show the inverse after a done pulse, and zero before the first one
   always @(posedge sys_clk)
   begin
      if (!rst && (ssIssue || csIssue))
      begin
         kind = csIssue;
         repeat (3) @(posedge sys_clk);
         xferDone <= 1'h1;
         xferIsCs <= kind;
         xferUframe <= issueUframe;
         rxCount <= cnt;
         errs <= err;
         @(posedge sys_clk);
         xferDone <= 1'h0;
         xferIsCs <= !kind;
         xferUframe <= ~issueUframe;
         rxCount <= ~cnt;
         errs <= ~err;
      end
   end
endmodule

// File: testbench/split_interrupt_descriptor_upper_tb.sv
// self-checking bench for the split interrupt descriptor upper words
`timescale 1ns/1ps
module split_interrupt_descriptor_upper_tb;
   logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, uframeStart;
   logic xferDone, xferIsCs, ssIssue, csIssue, irq, dir, aw, w, b;
   logic [4:0] s_axi_awaddr, s_axi_araddr, frameNum;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] uframeNum, xferUframe, issueUframe, errs, err, n, code;
   logic [7:0] rxCount, cnt;
   logic [17:0] rows [9] = '{{1'h1,3'h0,8'h11,3'h0,3'h0}, {1'h1,3'h1,8'h22,3'h7,3'h3},
      {1'h1,3'h3,8'h44,3'h0,3'h0}, {1'h0,3'h4,8'h55,3'h7,3'h5}, {1'h0,3'h5,8'h66,3'h4,3'h4},
      {1'h0,3'h6,8'h77,3'h0,3'h0}, {1'h0,3'h7,8'h88,3'h1,3'h1}, {1'h1,3'h0,8'h99,3'h0,3'h0},
      {1'h0,3'h2,8'hAA,3'h2,3'h0}};
   int n_fail = 0, n_compared = 0, ss, cs;
   split_interrupt_descriptor_upper dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uframeStart, .uframeNum, .frameNum, .xferDone,
      .xferIsCs, .xferUframe, .rxCount, .errTxn(errs[0]), .errBabble(errs[1]),
      .errUnderrun(errs[2]), .ssIssue, .csIssue, .issueUframe, .irq);
   split_device_model peer (.sys_clk, .rst, .ssIssue, .csIssue, .issueUframe, .cnt, .err,
      .xferDone, .xferIsCs, .xferUframe, .rxCount, .errs);
   // ==========================================
   // bus and check tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // samples at the falling edge, acts at the next rising edge
   task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(negedge sys_clk);
         {aw, w, b} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
         r = s_axi_bresp;
         @(posedge sys_clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
      end while (!b);
      s_axi_bready <= 1'h0;
      // unaligned offsets are unmapped and answer with an error
      chk(32'(r), 32'({a[1:0] != 2'h0, 1'h0}));
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do
      begin
         @(negedge sys_clk);
         {aw, b, v} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata};
         r = s_axi_rresp;
         @(posedge sys_clk);
         if (aw) s_axi_arvalid <= 1'h0;
      end while (!b);
      s_axi_rready <= 1'h0;
      chk(32'(r), 32'({a[1:0] != 2'h0, 1'h0}));
   endtask
   task automatic uf(input logic [2:0] k);
      @(posedge sys_clk);
      {uframeStart, uframeNum} <= {1'h1, k};
      @(posedge sys_clk);
      uframeStart <= 1'h0;
      {ss, cs} = 0;
      repeat (10)
      begin
         @(negedge sys_clk);
         ss += ssIssue;
         cs += csIssue;
      end
   endtask
   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================
   // stimulus
   initial
   begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial
   begin
      #500000;
      n_fail++;
      stop_test();
   end
   initial
   begin
      {rst, frameNum, cnt, err} = {1'h1, 5'h03, 11'h0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, uframeStart, uframeNum} = 50'h0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      rd(split_int_pkg::OFF_WORD4, d);
      chk(d, 32'h0);
      chk(32'(irq), 32'h0);
      wr(split_int_pkg::OFF_WORD7, 32'hABCDEF00, 4'hF);
      foreach (rows[i])
      begin
         {dir, n, cnt, err, code} = rows[i];
         wr(split_int_pkg::OFF_CTRL, {19'h0, 5'h03, 7'h0, dir}, 4'hF);
         wr(split_int_pkg::OFF_WORD4, 32'h1 << n, 4'h1);
         uf(n);
         chk(32'(ss), 32'h1);
         chk(32'(cs), 32'h0);
         rd(5'(4 * split_int_pkg::CNT_WORD[n]), d);
         chk((d >> split_int_pkg::CNT_LSB[n]) & 32'hFF, 32'(cnt));
         rd(split_int_pkg::OFF_WORD4, d);
         chk((d >> (8 + 3 * n)) & 32'h7, 32'(code));
         chk(d & 32'hFF, 32'h0);
      end
      rd(split_int_pkg::OFF_WORD7, d);
      chk(d, 32'hABCDEF88);
      wr(split_int_pkg::OFF_IRQSTAT, 32'h7, 4'hF);
      wr(split_int_pkg::OFF_IRQMASK, 32'h7, 4'hF);
      wr(split_int_pkg::OFF_CTRL, 32'h0301, 4'hF);
      wr(split_int_pkg::OFF_WORD4, 32'h01, 4'h1);
      wr(split_int_pkg::OFF_WORD5, 32'h04, 4'h1);
      uf(3'h0);
      chk(32'(2 * ss + cs), 32'h2);
      uf(3'h2);
      chk(32'(2 * ss + cs), 32'h1);
      rd(split_int_pkg::OFF_WORD5, d);
      chk(d & 32'hFF, 32'h0);
      chk(32'(irq), 32'h1);
      wr(split_int_pkg::OFF_IRQMASK, 32'h0, 4'hF);
      @(negedge sys_clk);
      chk(32'(irq), 32'h0);
      wr(split_int_pkg::OFF_IRQMASK, 32'h7, 4'hF);
      wr(split_int_pkg::OFF_IRQSTAT, 32'h7, 4'hF);
      @(negedge sys_clk);
      chk(32'(irq), 32'h0);
      wr(split_int_pkg::OFF_CTRL, 32'h0300, 4'hF);
      wr(split_int_pkg::OFF_WORD5, 32'h08, 4'h1);
      uf(3'h3);
      chk(32'(cs), 32'h0);
      wr(split_int_pkg::OFF_CTRL, 32'h0301, 4'hF);
      wr(split_int_pkg::OFF_WORD4, 32'h10, 4'h1);
      uf(3'h4);
      chk(32'(ss), 32'h0);
      wr(split_int_pkg::OFF_WORD4, 32'h01, 4'h1);
      frameNum <= 5'h04;
      uf(3'h0);
      chk(32'(ss), 32'h0);
      wr(5'h06, 32'hFFFFFFFF, 4'hF);
      rd(5'h02, d);
      chk(d, 32'h0);
      rd(split_int_pkg::OFF_FRAME, d);
      chk(d, 32'h4);
      // reset again in mid-run: stored word 7 must fall back to zero
      rst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      rd(split_int_pkg::OFF_WORD7, d);
      chk(d, 32'h0);
      stop_test();
   end
endmodule
